// ---- core/rclk2_pkg.sv ----
// Constants for the second recovered-clock output controller
`default_nettype none
package rclk2_pkg;
  // Register map, byte addresses on the 32-bit bus
  localparam logic [7:0]  CTRL_OFFSET   = 8'h18;
  localparam logic [7:0]  STATUS_OFFSET = 8'h1C;
  localparam int          ADR_W         = 8;
  // Control field positions
  localparam int          EN_BIT        = 15;
  localparam int          SRC_MSB       = 14;
  localparam int          SRC_LSB       = 11;
  localparam int          FREQ_MSB      = 10;
  localparam int          FREQ_LSB      = 8;
  localparam int          SQL_MSB       = 5;
  localparam int          SQL_LSB       = 4;
  localparam int          TYPE_MSB      = 2;
  localparam int          TYPE_LSB      = 0;
  // Reset value and writable bits; reserved 7:6 and 3 stay zero
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK    = 16'hFF37;
  // Source port codes above this are reserved
  localparam logic [3:0]  SRC_LAST      = 4'h3;
  // Output frequency codes
  localparam logic [2:0]  FREQ_25       = 3'h0;
  localparam logic [2:0]  FREQ_125      = 3'h1;
  localparam logic [2:0]  FREQ_31       = 3'h2;
  // Clock type code for the copper receive-recovered clock
  localparam logic [2:0]  TYPE_CU_RX    = 3'h1;
  // Squelch levels
  typedef enum logic [1:0] {
    SQL_STRICT = 2'b00,
    SQL_RELAX  = 2'b01,
    SQL_LINK   = 2'b10,
    SQL_NONE   = 2'b11
  } squelch_level_e;
endpackage
`default_nettype wire

// ---- core/rclk_sel_if.sv ----
// Selected-port status and settings passed to the squelch policy
`default_nettype none
interface rclk_sel_if;
  logic                           link_up;
  logic                           unstable;
  logic                           gig_master;
  logic                           ten_mb;
  logic                           eee;
  logic                           lp_idle;
  logic                           cfg_ok;
  logic                           enable;
  logic                           ext_squelch;
  rclk2_pkg::squelch_level_e      level;
  modport drive  (output link_up, unstable, gig_master, ten_mb, eee, lp_idle,
                  cfg_ok, enable, ext_squelch, level);
  modport decide (input link_up, unstable, gig_master, ten_mb, eee, lp_idle,
                  cfg_ok, enable, ext_squelch, level);
endinterface
`default_nettype wire

// ---- core/rclk_squelch_policy.sv ----
// Decides whether the recovered clock may pass for the selected port
`default_nettype none
module rclk_squelch_policy (
  input  wire logic   clk,
  input  wire logic   rstn,
  rclk_sel_if.decide  sel,
  output logic        allow
);
  logic level_ok;

  // Link-state policy per squelch level
  always_comb begin
    case (sel.level)
      rclk2_pkg::SQL_STRICT: level_ok = sel.link_up && !sel.unstable && !sel.gig_master
                                        && !sel.ten_mb && !sel.eee;
      rclk2_pkg::SQL_RELAX:  level_ok = sel.link_up && !sel.unstable
                                        && (!sel.eee || sel.lp_idle);
      rclk2_pkg::SQL_LINK:   level_ok = sel.link_up;
      rclk2_pkg::SQL_NONE:   level_ok = 1'b1;
      default:               level_ok = 1'b0;
    endcase
  end

  // The pin beats every field; reserved settings never pass a clock
  assign allow = level_ok && sel.enable && sel.cfg_ok && !sel.ext_squelch;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_strict_master;
    sel.level == rclk2_pkg::SQL_STRICT && sel.gig_master |-> !allow;
  endproperty
  a_strict_master: assert property (p_strict_master) else $error("strict level passed master");

  property p_relax_master;
    sel.level == rclk2_pkg::SQL_RELAX && sel.link_up && !sel.unstable && !sel.eee
      && sel.enable && sel.cfg_ok && !sel.ext_squelch |-> allow;
  endproperty
  a_relax_master: assert property (p_relax_master) else $error("relaxed level squelched");

  property p_link_down;
    sel.level == rclk2_pkg::SQL_LINK && !sel.link_up |-> !allow;
  endproperty
  a_link_down: assert property (p_link_down) else $error("link level passed on link down");

  property p_no_squelch;
    sel.level == rclk2_pkg::SQL_NONE && sel.enable && sel.cfg_ok && !sel.ext_squelch |-> allow;
  endproperty
  a_no_squelch: assert property (p_no_squelch) else $error("level 11 squelched");
endmodule // rclk_squelch_policy
`default_nettype wire

// ---- core/rclk_glitch_gate.sv ----
// Glitch-free gate: opens and closes only while the source is low
`default_nettype none
module rclk_glitch_gate (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic src,
  input  wire logic allow,
  output logic      out_reg,
  output logic      gate_reg
);
  logic gate_next;

  // Gate follows allow only in the source's low phase, so no pulse is cut
  assign gate_next = src ? gate_reg : allow;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
    end
  end

  // Output flop; held low whenever the gate is shut
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= gate_next & src;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_shut_low;
    !allow && !src |=> !out_reg;
  endproperty
  a_shut_low: assert property (p_shut_low) else $error("output not low when shut");

  property p_clean_start;
    $rose(out_reg) |-> $past(gate_reg);
  endproperty
  a_clean_start: assert property (p_clean_start) else $error("output rose on open gate edge");
endmodule // rclk_glitch_gate
`default_nettype wire

// ---- core/rclk2_ctrl.sv ----
// Second recovered-clock output: control register, source select, squelch
// Summary of operation
// - Control fields live in one 16-bit register at offset 0x18.
// - Bit 15 enables the output; resets to 0, output starts disabled.
// - Bits 14:11 pick source port 0 to 3; other codes reserved; reset 0.
// - Bits 10:8 pick 25, 125 or 31.25 MHz; higher codes reserved; reset 0.
// - Level 00 squelches on link down, unstable, gigabit master, 10 Mb/s, EEE.
// - Level 01 like 00 but passes gigabit master, 10 Mb/s, and LPI reception.
// - Level 10 squelches only while the link is down.
// - Level 11 never squelches, even with the link down.
// - External squelch pin high squelches the output regardless of settings.
// - Bits 2:0 pick clock type; 001 is copper receive clock; reset 0.
//
// The implementer's own choice: register access over Wishbone.
`default_nettype none
module rclk2_ctrl (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // Wishbone classic slave
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Per-port recovered clocks, one line per output frequency
  input  wire logic [3:0]  RCLK_25,
  input  wire logic [3:0]  RCLK_125,
  input  wire logic [3:0]  RCLK_31,
  // Per-port link state
  input  wire logic [3:0]  LINK_UP,
  input  wire logic [3:0]  LINK_UNSTABLE,
  input  wire logic [3:0]  GIG_MASTER,
  input  wire logic [3:0]  TEN_MB,
  input  wire logic [3:0]  EEE_MODE,
  input  wire logic [3:0]  LP_IDLE_RX,
  // External squelch, active high
  input  wire logic        CLK_SQUELCH,
  output logic             RECOVERED_CLOCK_OUT_TWO
);
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        req;
  logic        wr_ctrl;
  logic [15:0] lane_mask;
  logic [3:0]  src_port;
  logic [2:0]  freq_code;
  logic [2:0]  type_code;
  logic [1:0]  port_idx;
  logic        src_clk;
  logic        allow;
  logic        gate;
  rclk_sel_if  sel ();

  // Bit of a four-port vector chosen by the port index
  function automatic logic pick(input logic [3:0] vec, input logic [1:0] idx);
    pick = vec[idx];
  endfunction

  // New request: strobe up and not yet answered
  assign req     = WB_CYC_I && WB_STB_I && !ack_reg;
  assign wr_ctrl = req && WB_WE_I && (WB_ADR_I == rclk2_pkg::CTRL_OFFSET);

  // Byte lanes 0 and 1 cover the 16-bit register
  assign lane_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Masked write; reserved bits never take data
  assign ctrl_next = (ctrl_reg & ~(lane_mask & rclk2_pkg::CTRL_WMASK))
                   | (WB_DAT_I[15:0] & lane_mask & rclk2_pkg::CTRL_WMASK);

  // Control register
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= rclk2_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Answer every strobe in one cycle; unmapped addresses read zero
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Read mux; upper half and reserved bits read zero
  always_comb begin
    dat_next = 32'h0000_0000;
    case (WB_ADR_I)
      rclk2_pkg::CTRL_OFFSET:   dat_next = {16'h0000, ctrl_reg};
      rclk2_pkg::STATUS_OFFSET: dat_next = {29'h0000_0000, RECOVERED_CLOCK_OUT_TWO,
                                            gate, allow};
      default:                  dat_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dat_reg <= 32'h0000_0000;
    end else if (req) begin
      dat_reg <= dat_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  // Field decode
  assign src_port  = ctrl_reg[rclk2_pkg::SRC_MSB:rclk2_pkg::SRC_LSB];
  assign freq_code = ctrl_reg[rclk2_pkg::FREQ_MSB:rclk2_pkg::FREQ_LSB];
  assign type_code = ctrl_reg[rclk2_pkg::TYPE_MSB:rclk2_pkg::TYPE_LSB];
  assign port_idx  = src_port[1:0];

  // Source clock: reserved frequency codes give a quiet line
  always_comb begin
    case (freq_code)
      rclk2_pkg::FREQ_25:  src_clk = pick(RCLK_25, port_idx);
      rclk2_pkg::FREQ_125: src_clk = pick(RCLK_125, port_idx);
      rclk2_pkg::FREQ_31:  src_clk = pick(RCLK_31, port_idx);
      default:             src_clk = 1'b0;
    endcase
  end

  // Selected-port status handed to the policy
  assign sel.link_up     = pick(LINK_UP, port_idx);
  assign sel.unstable    = pick(LINK_UNSTABLE, port_idx);
  assign sel.gig_master  = pick(GIG_MASTER, port_idx);
  assign sel.ten_mb      = pick(TEN_MB, port_idx);
  assign sel.eee         = pick(EEE_MODE, port_idx);
  assign sel.lp_idle     = pick(LP_IDLE_RX, port_idx);
  assign sel.enable      = ctrl_reg[rclk2_pkg::EN_BIT];
  assign sel.ext_squelch = CLK_SQUELCH;
  assign sel.level       = rclk2_pkg::squelch_level_e'(
                             ctrl_reg[rclk2_pkg::SQL_MSB:rclk2_pkg::SQL_LSB]);
  // Reserved port, frequency or type codes keep the output squelched
  assign sel.cfg_ok      = (src_port <= rclk2_pkg::SRC_LAST)
                        && (freq_code <= rclk2_pkg::FREQ_31)
                        && (type_code == rclk2_pkg::TYPE_CU_RX);

  rclk_squelch_policy u_policy (
    .clk   (SYS_CLK),
    .rstn  (RESETN),
    .sel   (sel),
    .allow (allow)
  );

  // Output flop sits in the gate so the pin never glitches
  rclk_glitch_gate u_gate (
    .clk      (SYS_CLK),
    .rstn     (RESETN),
    .src      (src_clk),
    .allow    (allow),
    .out_reg  (RECOVERED_CLOCK_OUT_TWO),
    .gate_reg (gate)
  );

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  property p_ack_next;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after strobe");

  property p_ack_drop;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

  property p_write_lands;
    wr_ctrl && WB_SEL_I[1] |=> ctrl_reg[rclk2_pkg::EN_BIT] == $past(WB_DAT_I[15]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("enable bit not written");

  property p_reserved_zero;
    WB_ACK_O && (WB_ADR_I == rclk2_pkg::CTRL_OFFSET) |->
      WB_DAT_O[7:6] == 2'b00 && !WB_DAT_O[3] && WB_DAT_O[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_pin_squelch;
    CLK_SQUELCH && !src_clk ##1 CLK_SQUELCH |-> !RECOVERED_CLOCK_OUT_TWO;
  endproperty
  a_pin_squelch: assert property (p_pin_squelch) else $error("output ran under squelch pin");

  property p_bad_port;
    src_port > rclk2_pkg::SRC_LAST |-> !allow;
  endproperty
  a_bad_port: assert property (p_bad_port) else $error("reserved port passed clock");

  property p_bad_type;
    type_code != rclk2_pkg::TYPE_CU_RX |-> !allow;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("reserved type passed clock");

  property p_bad_freq;
    freq_code > rclk2_pkg::FREQ_31 |-> !allow;
  endproperty
  a_bad_freq: assert property (p_bad_freq) else $error("reserved frequency passed clock");

  property p_disabled_low;
    !ctrl_reg[rclk2_pkg::EN_BIT] && !src_clk |=> !RECOVERED_CLOCK_OUT_TWO;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("output ran while disabled");
endmodule // rclk2_ctrl
`default_nettype wire

// ---- testbench/rclk_sink_model.sv ----
// Timing-device model that counts and times pulses of the recovered clock
`default_nettype none
module rclk_sink_model (
  input  wire logic clk,
  input  wire logic clk_in,
  input  wire logic clear,
  output int        edges,
  output int        min_high
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_reg;
  int   run_reg;
  // Sampled in the system clock domain; the output is a registered level there
  always @(posedge clk) begin
    prev_reg <= clk_in;
    run_reg  <= clk_in ? run_reg + 1 : 0;
    if (clear) begin
      edges    <= 0;
      min_high <= 99;
    end else begin
      if (clk_in && !prev_reg) edges <= edges + 1;
      // A truncated high phase shows up as a short run here
      if (!clk_in && prev_reg && run_reg < min_high) min_high <= run_reg;
    end
  end
endmodule // rclk_sink_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the second recovered-clock output controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        SYS_CLK, RESETN, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O, CLK_SQUELCH, RCO;
  logic [7:0]  WB_ADR_I;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic [3:0]  WB_SEL_I, LINK_UP, LINK_UNSTABLE, GIG_MASTER, TEN_MB, EEE_MODE, LP_IDLE_RX;
  logic [2:0]  cnt;
  logic        clear;
  int          edges, min_high, bad_count, checked;
  logic [31:0] rd;
  rclk2_ctrl rclk2_ctrl_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .RCLK_25({4{cnt[1]}}), .RCLK_125({4{cnt[0]}}), .RCLK_31({4{cnt[2]}}),
    .LINK_UP(LINK_UP), .LINK_UNSTABLE(LINK_UNSTABLE), .GIG_MASTER(GIG_MASTER),
    .TEN_MB(TEN_MB), .EEE_MODE(EEE_MODE), .LP_IDLE_RX(LP_IDLE_RX),
    .CLK_SQUELCH(CLK_SQUELCH), .RECOVERED_CLOCK_OUT_TWO(RCO));
  rclk_sink_model rclk_sink_model_inst (.clk(SYS_CLK), .clk_in(RCO), .clear(clear),
    .edges(edges), .min_high(min_high));
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  // Source clocks divided from one counter: periods of 2, 4 and 8 cycles
  always @(posedge SYS_CLK) cnt <= cnt + 3'h1;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One classic cycle; waits for ack under a bounded count
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= 4'h3;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    rd = WB_DAT_O;
    if (n >= 20) check("ack", 32'h0, 32'h1);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] src, input logic [2:0] fq,
                                      input logic [1:0] lvl, input logic [2:0] typ);
    return {16'h0000, 1'b1, src, fq, 2'b00, lvl, 1'b0, typ};
  endfunction
  // Let the gate settle, then count rising edges over 64 cycles
  task automatic meas(input string name, input int exp);
    repeat (16) @(posedge SYS_CLK);
    clear <= 1'b1;
    @(posedge SYS_CLK);
    clear <= 1'b0;
    repeat (64) @(posedge SYS_CLK);
    #1 check(name, edges, exp);
  endtask
  task automatic set_status(input logic [5:0] s);
    {LP_IDLE_RX, EEE_MODE, TEN_MB, GIG_MASTER, LINK_UNSTABLE, LINK_UP} <=
      {{4{s[5]}}, {4{s[4]}}, {4{s[3]}}, {4{s[2]}}, {4{s[1]}}, {4{s[0]}}};
  endtask
  task automatic t_reset();
    set_status(6'h01);
    wb(1'b0, 8'h18, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    meas("off_edges", 0);
  endtask
  task automatic t_regs();
    wb(1'b1, 8'h18, 32'hFFFFFFFF);
    wb(1'b0, 8'h18, 32'h0);
    check("ctrl_mask", rd, 32'h0000FF37);
    wb(1'b0, 8'h24, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic t_freq();
    int exp[4] = '{16, 32, 8, 0};
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, 8'h18, cfg(4'h0, f[2:0], 2'b11, 3'h1));
      meas("freq_edges", exp[f]);
    end
    wb(1'b1, 8'h18, cfg(4'h0, 3'h0, 2'b11, 3'h0));
    meas("type_reserved", 0);
  endtask
  task automatic t_port();
    set_status(6'h00);
    // Second update on a later edge so no signal gets two assignments in one step
    @(posedge SYS_CLK);
    LINK_UP <= 4'h4;
    for (int s = 0; s < 5; s++) begin
      wb(1'b1, 8'h18, cfg(s[3:0], 3'h0, 2'b00, 3'h1));
      meas("port_edges", (s == 2) ? 16 : 0);
    end
  endtask
  task automatic t_levels();
    // Status {lpi,eee,ten,gig,unstable,up} and which levels pass, bit per level
    logic [5:0] st[7] = '{6'h00, 6'h03, 6'h05, 6'h09, 6'h11, 6'h31, 6'h01};
    logic [3:0] ok[7] = '{4'h8, 4'hC, 4'hE, 4'hE, 4'hC, 4'hE, 4'hF};
    for (int c = 0; c < 7; c++) begin
      set_status(st[c]);
      for (int l = 0; l < 4; l++) begin
        wb(1'b1, 8'h18, cfg(4'h0, 3'h0, l[1:0], 3'h1));
        meas("level_edges", ok[c][l] ? 16 : 0);
      end
    end
  endtask
  task automatic t_pin();
    set_status(6'h00);
    wb(1'b1, 8'h18, cfg(4'h0, 3'h0, 2'b11, 3'h1));
    CLK_SQUELCH <= 1'b1;
    meas("pin_edges", 0);
    check("pin_level", RCO, 1'b0);
    // Status: allow, gate and output all low under the pin
    wb(1'b0, 8'h1C, 32'h0);
    check("status_squelched", rd, 32'h0);
    CLK_SQUELCH <= 1'b0;
    meas("pin_release", 16);
    // Status: allow and gate open once the pin is released
    wb(1'b0, 8'h1C, 32'h0);
    check("status_open", rd & 32'h0000_0003, 32'h0000_0003);
    // Squelch four times at two different phases of the source; no pulse may come out short
    for (int k = 0; k < 4; k++) begin
      repeat (5 + k) @(posedge SYS_CLK);
      CLK_SQUELCH <= 1'b1;
      repeat (3 + k) @(posedge SYS_CLK);
      CLK_SQUELCH <= 1'b0;
    end
    repeat (8) @(posedge SYS_CLK);
    #1 check("min_high", min_high, 2);
  endtask
  // Watchdog sized well above the expected run of about 3500 cycles
  initial begin
    #(25 * 20000);
    bad_count++;
    results();
  end
  initial begin
    {bad_count, checked} = 0;
    {RESETN, WB_WE_I, WB_CYC_I, WB_STB_I, CLK_SQUELCH, clear, cnt} = 0;
    {WB_ADR_I, WB_DAT_I, WB_SEL_I} = 0;
    {LINK_UP, LINK_UNSTABLE, GIG_MASTER, TEN_MB, EEE_MODE, LP_IDLE_RX} = 0;
    repeat (3) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    @(posedge SYS_CLK);
    t_reset();
    t_regs();
    t_freq();
    t_port();
    t_levels();
    t_pin();
    results();
  end
endmodule // tb_top
`default_nettype wire
